// [clkctl_defs.vh]
// constants for the main clock select and prescale block
// assumes the including file sits in the same folder
// How it works
// R1 - peripheral requests are routed to their oscillator
// R2 - requested internal oscillators start without software
// R3 - unused and unrequested sources are stopped
// R4 - standby-run bit keeps oscillator on, not power-down
// R5 - main clock runs active/idle, standby if needed
// R6 - power-down stops main clock after nvm idle
// R7 - software picks main source, switch is glitch-free
// R8 - external source switch waits for enough edges
// R9 - changes refused while waiting for external edges
// R10 - switch flag set while source change ongoing
// R11 - external clock and crystal report stability
// R12 - status bits show fast osc, ulp osc and crystal running and stable
// R13 - peripheral clock is prescaled, twelve settings 1..64
// R14 - after reset fast osc, divide by six
// R15 - fuse frequency field sets fast osc frequency
// R16 - trim fields load from fuses at reset
// R17 - trim lock fuse blocks trim writes
// R18 - trim locked when fast osc main and lock enabled
// R19 - main control and prescaler need unlock write
// R20 - trim writes also need unlock write
// R21 - software enables crystal before it can be used
// R22 - rtc, watchdog, sampled brownout request their clocks
// R23 - unlock key then write within four instructions
// R24 - writes without unlock leave register unchanged
// R25 - switch flag clears on takeover, no short pulses
`ifndef CLKCTL_DEFS_VH
`define CLKCTL_DEFS_VH
`define SRC_FAST 2'h0
`define SRC_ULP 2'h1
`define SRC_XTAL 2'h2
`define SRC_EXT 2'h3
`define MODE_ACTIVE 2'h0
`define MODE_IDLE 2'h1
`define MODE_STANDBY 2'h2
`define MODE_PDOWN 2'h3
`define DIV_RESET 4'h8
`define PEN_RESET 1'h1
`define UNLOCK_WINDOW 3'h4
`define EDGE_NEED 4'h4
`define SYNC_STAGES 2'h2
`endif

// [clk_glitchfree_mux.v]
// glitch-free two-to-one clock mux built from sampled source levels
// assumes sel and source levels are synchronous to the reference clock
`timescale 1ns/100ps
module clk_glitchfree_mux (
  input wire clk_i,    // reference clock
  input wire rst_i,    // async reset
  input wire ce_i,     // clock enable
  input wire sel_i,    // 1 picks source b
  input wire a_i,      // source a level
  input wire b_i,      // source b level
  output reg out_o,    // muxed clock level
  output wire b_on_o   // source b owns the output
);
  reg en_a_r;
  reg en_b_r;
  assign b_on_o = en_b_r;
  // break-before-make enables, changed only while sources are low
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_a_r <= 1'b1;
      en_b_r <= 1'b0;
      out_o <= 1'b0;
    end else if (ce_i) begin
      if (!a_i && en_a_r && sel_i)
        en_a_r <= 1'b0; // R25
      else if (!a_i && !en_b_r && !sel_i)
        en_a_r <= 1'b1;
      if (!b_i && en_b_r && !sel_i)
        en_b_r <= 1'b0;
      else if (!b_i && !en_a_r && sel_i)
        en_b_r <= 1'b1; // R7
      out_o <= (a_i & en_a_r) | (b_i & en_b_r);
    end
  end
endmodule // clk_glitchfree_mux

// [clk_prescaler.v]
// peripheral clock prescaler, twelve ratios from 1 to 64
// assumes the main clock level is sampled on the reference clock
`timescale 1ns/100ps
`include "clkctl_defs.vh"
module clk_prescaler (
  input wire clk_i,         // reference clock
  input wire rst_i,         // async reset
  input wire ce_i,          // clock enable
  input wire main_i,        // main clock level
  input wire pen_i,         // prescaler on
  input wire [3:0] div_i,   // ratio code
  output reg per_o          // peripheral clock level
);
  reg main_d_r;
  reg [6:0] cnt_r;
  wire rise = main_i & ~main_d_r;
  // ratio code to division factor
  function [6:0] ratio;
    input [3:0] c;
    begin
      case (c)
        4'h0: ratio = 7'h02;
        4'h1: ratio = 7'h04;
        4'h2: ratio = 7'h08;
        4'h3: ratio = 7'h10;
        4'h4: ratio = 7'h20;
        4'h5: ratio = 7'h40;
        4'h8: ratio = 7'h06;
        4'h9: ratio = 7'h0A;
        4'hA: ratio = 7'h0C;
        4'hB: ratio = 7'h18;
        4'hC: ratio = 7'h30;
        default: ratio = 7'h02;
      endcase
    end
  endfunction
  // divide on main edges; pen low passes main through
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_d_r <= 1'b0;
      cnt_r <= 7'h00;
      per_o <= 1'b0;
    end else if (ce_i) begin
      main_d_r <= main_i;
      if (!pen_i)
        per_o <= main_i; // R13
      else if (rise) begin
        if (cnt_r >= ratio(div_i) - 7'h01) begin
          cnt_r <= 7'h00;
          per_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 7'h01;
          if (cnt_r == (ratio(div_i) >> 1) - 7'h01)
            per_o <= 1'b0; // R13
        end
      end
    end
  end
endmodule // clk_prescaler

// [clk_main_ctrl.v]
// main clock controller: requests, source select, prescale, trims
// assumes all inputs synchronous to REF_CLK_I; clocks are levels
`timescale 1ns/100ps
`include "clkctl_defs.vh"
module clk_main_ctrl #(
  parameter TRIM_A_W = 7,
  parameter TRIM_B_W = 4
) (
  input wire REF_CLK_I,            // reference clock 25 MHz
  input wire RESET_I,              // async reset, high
  input wire CE_I,                 // clock enable
  input wire REQ_FAST_I,           // peripheral wants fast osc
  input wire REQ_ULP_I,            // peripheral wants ulp osc
  input wire REQ_XTAL_I,           // peripheral wants crystal
  input wire REQ_EXT_I,            // peripheral wants ext clock
  input wire REQ_MAIN_I,           // peripheral wants main clock
  input wire RTC_EN_I,             // rtc enabled
  input wire RTC_ON_XTAL_I,        // rtc clocked from crystal
  input wire WDT_EN_I,             // watchdog enabled
  input wire BOD_SAMPLED_I,        // brownout in sampled mode
  input wire [1:0] SLEEP_MODE_I,   // sleep mode
  input wire NVM_BUSY_I,           // nvm operation pending
  input wire FAST_LVL_I,           // fast osc level
  input wire ULP_LVL_I,            // ulp osc level
  input wire XTAL_LVL_I,           // crystal level
  input wire EXT_LVL_I,            // ext clock pin level
  input wire FAST_RDY_I,           // fast osc stable
  input wire ULP_RDY_I,            // ulp osc stable
  input wire XTAL_RDY_I,           // crystal stable
  input wire [1:0] FREQ_FUSE_I,    // freq select fuse field
  input wire [6:0] TRIM_A_FUSE_I,  // center trim fuse
  input wire [3:0] TRIM_B_FUSE_I,  // slope trim fuse
  input wire TRIM_LOCK_FUSE_I,     // trim lock fuse
  input wire UNLOCK_KEY_I,         // key written, pulse
  input wire WR_MAIN_A_I,          // write main control a, pulse
  input wire [1:0] WR_SRC_I,       // new source select
  input wire WR_PIN_OUT_I,         // new clock out pin enable
  input wire WR_PRESC_I,           // write prescaler, pulse
  input wire [3:0] WR_DIV_I,       // new ratio code
  input wire WR_PEN_I,             // new prescaler enable
  input wire WR_TRIM_LOCK_ENABLE_I,          // write trim lock enable, pulse
  input wire WR_TRIM_LOCK_ENABLE_D_I,        // new trim lock enable
  input wire WR_TRIM_A_I,          // write trim a, pulse
  input wire [6:0] WR_TRIM_A_D_I,  // new center trim
  input wire WR_TRIM_B_I,          // write trim b, pulse
  input wire [3:0] WR_TRIM_B_D_I,  // new slope trim
  input wire WR_OSC_CTL_I,         // write osc controls, pulse
  input wire [3:0] WR_STDBY_I,     // new standby-run bits
  input wire WR_XTAL_EN_I,         // new crystal enable
  output wire [3:0] OSC_EN_O,      // oscillator run enables
  output reg MAIN_CLK_O,           // main clock level
  output wire PER_CLK_O,           // peripheral clock level
  output wire CLOCK_OUTPUT_PIN_PIN_O,        // clock output pin
  output reg [1:0] SRC_SEL_O,      // current source select
  output reg [3:0] DIV_O,          // ratio code
  output reg PEN_O,                // prescaler enabled
  output reg SWITCHING_O,          // switch in progress
  output wire EXT_STABLE_O,        // ext clock stable
  output wire XTAL_STABLE_O,       // crystal stable
  output wire FAST_STABLE_O,       // fast osc status
  output wire ULP_STABLE_O,        // ulp osc status
  output reg [1:0] FREQ_SEL_O,     // fast osc frequency
  output reg [6:0] TRIM_A_O,       // center trim
  output reg [3:0] TRIM_B_O,       // slope trim
  output reg TRIM_LOCK_ENABLE_O              // trim lock enable
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EDGE = 2'h1;
  localparam ST_SWAP = 2'h2;
  reg [2:0] unlock_cnt_r;
  reg [3:0] stdby_r;
  reg xtal_en_r;
  reg pin_out_r;
  reg [1:0] state_r;
  reg [1:0] cur_r;
  reg [1:0] tgt_r;
  reg [3:0] edges_r;
  reg ext_d_r;
  reg ext_seen_r;
  reg sel_b_r;
  reg fuse_loaded_r;
  wire mux_b_on;
  wire mux_out;
  wire unlocked = (unlock_cnt_r != 3'h0);
  wire pdown = (SLEEP_MODE_I == `MODE_PDOWN);
  wire main_need;
  wire [3:0] req;
  wire trim_locked;
  wire cur_lvl;
  wire tgt_lvl;
  // source level pick
  function lvl_of;
    input [1:0] s;
    input [3:0] l;
    begin
      lvl_of = l[s];
    end
  endfunction
  // unlock window counts instructions, approximated as cycles
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I)
      unlock_cnt_r <= 3'h0;
    else if (CE_I) begin
      if (UNLOCK_KEY_I)
        unlock_cnt_r <= `UNLOCK_WINDOW; // R23
      else if (unlocked)
        unlock_cnt_r <= unlock_cnt_r - 3'h1;
    end
  end
  // main clock needed by sleep mode and nvm state
  assign main_need = (SLEEP_MODE_I == `MODE_ACTIVE) | // R5
    (SLEEP_MODE_I == `MODE_IDLE) |
    ((SLEEP_MODE_I == `MODE_STANDBY) &
     (REQ_MAIN_I | stdby_r[cur_r])) | // R5
    (pdown & NVM_BUSY_I); // R6
  // route requests, including asynchronous peripheral clocks
  assign req[`SRC_FAST] = REQ_FAST_I; // R1
  assign req[`SRC_ULP] = REQ_ULP_I | WDT_EN_I | BOD_SAMPLED_I |
    (RTC_EN_I & ~RTC_ON_XTAL_I); // R22
  assign req[`SRC_XTAL] = REQ_XTAL_I | (RTC_EN_I & RTC_ON_XTAL_I); // R22
  assign req[`SRC_EXT] = REQ_EXT_I; // R1
  // oscillator enables: requested, in use, or standby-run
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : osc_en
      wire in_use = main_need & ((cur_r == g) |
        ((state_r != ST_IDLE) & (tgt_r == g)));
      wire keep = stdby_r[g] & ~pdown; // R4
      wire run = req[g] | in_use | keep; // R2 R3
      if (g == `SRC_XTAL)
        assign OSC_EN_O[g] = run & xtal_en_r; // R21
      else
        assign OSC_EN_O[g] = run;
    end
  endgenerate
  // status bits
  assign FAST_STABLE_O = FAST_RDY_I & OSC_EN_O[`SRC_FAST]; // R12
  assign ULP_STABLE_O = ULP_RDY_I & OSC_EN_O[`SRC_ULP]; // R12
  assign XTAL_STABLE_O = XTAL_RDY_I & OSC_EN_O[`SRC_XTAL]; // R11
  assign EXT_STABLE_O = ext_seen_r; // R11
  assign trim_locked = TRIM_LOCK_FUSE_I |
    (TRIM_LOCK_ENABLE_O & (cur_r == `SRC_FAST)); // R17 R18
  // protected control registers and fuse load
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DIV_O <= `DIV_RESET; // R14
      PEN_O <= `PEN_RESET; // R14
      TRIM_LOCK_ENABLE_O <= 1'b0;
      stdby_r <= 4'h0;
      xtal_en_r <= 1'b0;
      pin_out_r <= 1'b0;
      TRIM_A_O <= 7'h00;
      TRIM_B_O <= 4'h0;
      FREQ_SEL_O <= 2'h0;
      fuse_loaded_r <= 1'b0;
    end else if (CE_I) begin
      if (!fuse_loaded_r) begin
        fuse_loaded_r <= 1'b1;
        FREQ_SEL_O <= FREQ_FUSE_I; // R15
        TRIM_A_O <= TRIM_A_FUSE_I; // R16
        TRIM_B_O <= TRIM_B_FUSE_I; // R16
      end else begin
        if (WR_PRESC_I && unlocked) begin // R19 R24
          DIV_O <= WR_DIV_I;
          PEN_O <= WR_PEN_I;
        end
        if (WR_MAIN_A_I && unlocked)
          pin_out_r <= WR_PIN_OUT_I; // R19
        if (WR_TRIM_LOCK_ENABLE_I && unlocked)
          TRIM_LOCK_ENABLE_O <= WR_TRIM_LOCK_ENABLE_D_I;
        if (WR_OSC_CTL_I && unlocked) begin
          stdby_r <= WR_STDBY_I;
          xtal_en_r <= WR_XTAL_EN_I;
        end
        if (WR_TRIM_A_I && unlocked && !trim_locked)
          TRIM_A_O <= WR_TRIM_A_D_I; // R20 R17
        if (WR_TRIM_B_I && unlocked && !trim_locked)
          TRIM_B_O <= WR_TRIM_B_D_I; // R20 R18
      end
    end
  end
  assign cur_lvl = lvl_of(cur_r, {EXT_LVL_I, XTAL_LVL_I, ULP_LVL_I,
    FAST_LVL_I});
  assign tgt_lvl = lvl_of(tgt_r, {EXT_LVL_I, XTAL_LVL_I, ULP_LVL_I,
    FAST_LVL_I});
  // source switch sequencer
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= ST_IDLE;
      cur_r <= `SRC_FAST; // R14
      tgt_r <= `SRC_FAST;
      edges_r <= 4'h0;
      ext_d_r <= 1'b0;
      ext_seen_r <= 1'b0;
      sel_b_r <= 1'b0;
      SWITCHING_O <= 1'b0;
    end else if (CE_I) begin
      ext_d_r <= EXT_LVL_I;
      if (edges_r >= `EDGE_NEED)
        ext_seen_r <= 1'b1;
      case (state_r)
        ST_IDLE: begin
          if (WR_MAIN_A_I && unlocked && WR_SRC_I != cur_r) begin // R7
            tgt_r <= WR_SRC_I;
            edges_r <= 4'h0;
            SWITCHING_O <= 1'b1; // R10
            state_r <= (WR_SRC_I == `SRC_EXT ||
              WR_SRC_I == `SRC_XTAL) ? ST_EDGE : ST_SWAP;
            sel_b_r <= (WR_SRC_I == `SRC_EXT ||
              WR_SRC_I == `SRC_XTAL) ? 1'b0 : 1'b1;
          end
        end
        ST_EDGE: begin
          // new writes ignored here until EDGE_NEED edges are counted or reset
          if (tgt_lvl && !ext_d_r && edges_r != 4'hF &&
              tgt_r == `SRC_EXT)
            edges_r <= edges_r + 4'h1; // R8 R9
          else if (tgt_r == `SRC_XTAL && XTAL_RDY_I &&
              edges_r != 4'hF)
            edges_r <= edges_r + 4'h1;
          if (edges_r >= `EDGE_NEED) begin
            sel_b_r <= 1'b1; // R8
            state_r <= ST_SWAP;
          end
        end
        ST_SWAP: begin
          if (mux_b_on) begin
            cur_r <= tgt_r;
            sel_b_r <= 1'b0;
            SWITCHING_O <= 1'b0; // R25
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // old source on leg a, new source on leg b while switching
  clk_glitchfree_mux u_mux (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .sel_i(sel_b_r),
    .a_i(cur_lvl),
    .b_i(tgt_lvl),
    .out_o(mux_out),
    .b_on_o(mux_b_on)
  );
  // gate main clock when not needed
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I)
      MAIN_CLK_O <= 1'b0;
    else if (CE_I)
      MAIN_CLK_O <= mux_out & main_need; // R5 R6
  end
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I)
      SRC_SEL_O <= `SRC_FAST;
    else if (CE_I)
      SRC_SEL_O <= cur_r;
  end
  clk_prescaler u_presc (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .main_i(MAIN_CLK_O),
    .pen_i(PEN_O),
    .div_i(DIV_O),
    .per_o(PER_CLK_O)
  );
  assign CLOCK_OUTPUT_PIN_PIN_O = PER_CLK_O & pin_out_r; // clock out
endmodule // clk_main_ctrl

// [clk_main_ctrl_assertions.sv]
// assertions for the main clock controller, bound to its ports
// assumes one reference clock and the async active-high reset
`timescale 1ns/100ps
module clk_main_ctrl_assertions (
  input wire REF_CLK_I, RESET_I, CE_I, REQ_ULP_I, NVM_BUSY_I,
  input wire [1:0] SLEEP_MODE_I, FREQ_FUSE_I, WR_SRC_I,
  input wire [1:0] SRC_SEL_O, FREQ_SEL_O,
  input wire UNLOCK_KEY_I, WR_PRESC_I, WR_PEN_I, WR_MAIN_A_I,
  input wire [3:0] WR_DIV_I, TRIM_B_FUSE_I, OSC_EN_O, DIV_O, TRIM_B_O,
  input wire [6:0] TRIM_A_FUSE_I, TRIM_A_O,
  input wire TRIM_LOCK_FUSE_I, MAIN_CLK_O, PEN_O, SWITCHING_O
);
  reg [2:0] win_r;
  reg ldd_r;
  // mirror of the unlock window and of the one-time fuse load
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      win_r <= 3'h0;
      ldd_r <= 1'b0;
    end else if (CE_I) begin
      win_r <= UNLOCK_KEY_I ? 3'h4 : win_r - {2'h0, win_r != 3'h0};
      ldd_r <= 1'b1;
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // unlocked prescaler write, a fresh source request, power-down idle
  sequence s_open_presc;
    WR_PRESC_I && CE_I && win_r != 3'h0;
  endsequence
  sequence s_new_src;
    WR_MAIN_A_I && CE_I && win_r != 3'h0 && !SWITCHING_O &&
      WR_SRC_I != SRC_SEL_O;
  endsequence
  sequence s_pd_idle;
    (SLEEP_MODE_I == 2'h3 && !NVM_BUSY_I) [*4];
  endsequence
  AST_RST_VALUES: assert property ($fell(RESET_I) |-> DIV_O == 4'h8 &&
    PEN_O && SRC_SEL_O == 2'h0 && !SWITCHING_O) else $error("reset values");
  AST_FUSE_LOAD: assert property (!ldd_r && CE_I |=>
    FREQ_SEL_O == $past(FREQ_FUSE_I) && TRIM_A_O == $past(TRIM_A_FUSE_I) &&
    TRIM_B_O == $past(TRIM_B_FUSE_I)) else $error("fuse load");
  AST_PRESC_LOCKED: assert property (WR_PRESC_I && CE_I && win_r == 3'h0
    |=> $stable(DIV_O) && $stable(PEN_O)) else $error("locked write took");
  AST_PRESC_WRITE: assert property (s_open_presc |=>
    DIV_O == $past(WR_DIV_I) && PEN_O == $past(WR_PEN_I))
    else $error("prescaler write lost");
  AST_SWITCH_SET: assert property (s_new_src |=> SWITCHING_O)
    else $error("switch flag not set");
  AST_SWITCH_DONE: assert property ($fell(SWITCHING_O) |->
    ##[0:2] $changed(SRC_SEL_O)) else $error("no takeover");
  AST_SRC_ONLY_SWITCH: assert property ($changed(SRC_SEL_O) |->
    $past(SWITCHING_O) || $past(SWITCHING_O, 2)) else $error("stray source");
  AST_TRIM_FUSE_LOCK: assert property (TRIM_LOCK_FUSE_I && ldd_r |=>
    $stable(TRIM_A_O) && $stable(TRIM_B_O)) else $error("trim changed");
  AST_ULP_REQ: assert property (REQ_ULP_I && SLEEP_MODE_I != 2'h3 |->
    OSC_EN_O[1]) else $error("request not routed");
  AST_PDOWN_STOP: assert property (s_pd_idle |=> !MAIN_CLK_O)
    else $error("main runs in power-down");
endmodule // clk_main_ctrl_assertions
bind clk_main_ctrl clk_main_ctrl_assertions u_chk (.*);

// [clk_sources_model.sv]
// oscillator and clock pin stand-ins on the controller's far side
// assumes run enables come straight from the controller
`timescale 1ns/100ps
module clk_sources_model (
  input wire clk_i,       // reference clock
  input wire rst_i,       // async reset
  input wire [3:0] en_i,  // run enables per source
  input wire ext_run_i,   // external pin is driven
  output reg [3:0] lvl_o, // source levels
  output reg [2:0] rdy_o  // internal and crystal stable
);
  integer k;
  reg [7:0] tick_r;
  // a source toggles at its own slow rate and stands still when stopped
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_r <= 8'h00;
      lvl_o <= 4'h0;
      rdy_o <= 3'h0;
    end else begin
      tick_r <= tick_r + 8'h01;
      rdy_o <= en_i[2:0];
      for (k = 0; k < 4; k = k + 1) begin
        if ((k < 3 ? en_i[k] : ext_run_i) && tick_r % (k + 2) == 0) begin
          lvl_o[k] <= ~lvl_o[k];
        end
      end
    end
  end
endmodule // clk_sources_model

// [tb.sv]
// self-checking bench for the main clock controller
// assumes the oscillator model and the bound checker are compiled
`timescale 1ns/100ps
module tb;
  reg REF_CLK_I, RESET_I, CE_I, REQ_FAST_I, REQ_ULP_I, REQ_XTAL_I, REQ_EXT_I;
  reg REQ_MAIN_I, RTC_EN_I, RTC_ON_XTAL_I, WDT_EN_I, BOD_SAMPLED_I;
  reg NVM_BUSY_I, TRIM_LOCK_FUSE_I, UNLOCK_KEY_I, WR_MAIN_A_I, WR_PIN_OUT_I;
  reg WR_PRESC_I, WR_PEN_I, WR_TRIM_LOCK_ENABLE_I, WR_TRIM_LOCK_ENABLE_D_I, WR_TRIM_A_I;
  reg WR_TRIM_B_I, WR_OSC_CTL_I, WR_XTAL_EN_I, ext_run;
  reg [1:0] SLEEP_MODE_I, FREQ_FUSE_I, WR_SRC_I;
  reg [6:0] TRIM_A_FUSE_I, WR_TRIM_A_D_I;
  reg [3:0] TRIM_B_FUSE_I, WR_DIV_I, WR_TRIM_B_D_I, WR_STDBY_I;
  wire FAST_LVL_I, ULP_LVL_I, XTAL_LVL_I, EXT_LVL_I;
  wire FAST_RDY_I, ULP_RDY_I, XTAL_RDY_I, MAIN_CLK_O, PER_CLK_O;
  wire CLOCK_OUTPUT_PIN_PIN_O, PEN_O, SWITCHING_O, EXT_STABLE_O, XTAL_STABLE_O;
  wire FAST_STABLE_O, ULP_STABLE_O, TRIM_LOCK_ENABLE_O;
  wire [3:0] OSC_EN_O, DIV_O, TRIM_B_O;
  wire [1:0] SRC_SEL_O, FREQ_SEL_O;
  wire [6:0] TRIM_A_O;
  integer failures, samples_checked, n, i;
  clk_main_ctrl DUT (.*);
  clk_sources_model SRC (.clk_i(REF_CLK_I), .rst_i(RESET_I),
    .en_i(OSC_EN_O), .ext_run_i(ext_run),
    .lvl_o({EXT_LVL_I, XTAL_LVL_I, ULP_LVL_I, FAST_LVL_I}),
    .rdy_o({XTAL_RDY_I, ULP_RDY_I, FAST_RDY_I}));
  // reference clock, 40 ns period
  initial begin
    REF_CLK_I = 1'b0;
    forever #20 REF_CLK_I = ~REF_CLK_I;
  end
  task chk(input [11:0] got, input [11:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task step(input integer c);
    repeat (c) @(negedge REF_CLK_I);
  endtask
  task do_reset;
    begin
      step(1);
      RESET_I = 1'b1;
      step(5);
      RESET_I = 1'b0;
      step(2);
    end
  endtask
  // key, then strobe 'which' after gap cycles; a gap of 5 is too late
  task wr(input integer which, input integer gap);
    begin
      step(1);
      UNLOCK_KEY_I = 1'b1;
      step(1);
      UNLOCK_KEY_I = 1'b0;
      step(gap - 1);
      {WR_TRIM_B_I, WR_OSC_CTL_I, WR_TRIM_LOCK_ENABLE_I, WR_MAIN_A_I, WR_TRIM_A_I,
        WR_PRESC_I} = 6'h01 << which;
      step(1);
      {WR_TRIM_B_I, WR_OSC_CTL_I, WR_TRIM_LOCK_ENABLE_I, WR_TRIM_A_I, WR_MAIN_A_I,
        WR_PRESC_I} = 6'h00;
    end
  endtask
  task wait_sw;
    begin
      n = 0;
      while (SWITCHING_O === 1'b1 && n < 200) begin
        step(1);
        n = n + 1;
      end
      step(2);
    end
  endtask
  task runs(input [1:0] mode, input exp);
    reg last;
    begin
      SLEEP_MODE_I = mode;
      step(6);
      n = 0;
      last = MAIN_CLK_O;
      repeat (24) begin
        step(1);
        n = n + (MAIN_CLK_O !== last);
        last = MAIN_CLK_O;
      end
      chk(n > 4, exp);
    end
  endtask
  // counts clock output pin toggles over 24 cycles; exp is "more than one"
  task pin_togs(input exp);
    reg last;
    begin
      n = 0;
      last = CLOCK_OUTPUT_PIN_PIN_O;
      repeat (24) begin
        step(1);
        n = n + (CLOCK_OUTPUT_PIN_PIN_O !== last);
        last = CLOCK_OUTPUT_PIN_PIN_O;
      end
      chk(n > 1, exp);
    end
  endtask
  task t_reset;
    begin
      chk({PEN_O, DIV_O, SRC_SEL_O}, 12'h0_60);
      chk(FREQ_SEL_O, 12'h002);
      chk({TRIM_B_O, TRIM_A_O}, 12'h0_35A);
      chk({FAST_STABLE_O, ULP_STABLE_O}, 12'h002);
      $display("test reset done");
    end
  endtask
  task t_presc;
    begin
      {WR_DIV_I, WR_PEN_I} = 5'h07;
      wr(0, 5);
      chk(DIV_O, 12'h008);
      for (i = 0; i < 13; i = i + 1) begin
        if (i != 6 && i != 7) begin
          WR_DIV_I = i[3:0];
          wr(0, 4);
          chk(DIV_O, i[3:0]);
        end
      end
      {WR_DIV_I, WR_PEN_I} = 5'h10;
      wr(0, 1);
      chk(PEN_O, 12'h000);
      WR_PIN_OUT_I = 1'b1;
      wr(2, 1);
      pin_togs(1'b1);
      {WR_DIV_I, WR_PEN_I} = 5'h0B;
      wr(0, 1);
      pin_togs(1'b0);
      {WR_DIV_I, WR_PEN_I} = 5'h11;
      wr(0, 1);
      $display("test prescaler done");
    end
  endtask
  task t_trim;
    begin
      {WR_TRIM_A_D_I, WR_TRIM_B_D_I} = 11'h2A_A;
      wr(1, 2);
      wr(5, 3);
      chk({TRIM_B_O, TRIM_A_O}, 12'h0_52A);
      WR_TRIM_A_D_I = 7'h11;
      wr(1, 6);
      chk(TRIM_A_O, 12'h02A);
      WR_TRIM_LOCK_ENABLE_D_I = 1'b1;
      wr(3, 1);
      wr(1, 1);
      chk({TRIM_LOCK_ENABLE_O, TRIM_A_O}, 12'h0AA);
      WR_TRIM_LOCK_ENABLE_D_I = 1'b0;
      wr(3, 1);
      TRIM_LOCK_FUSE_I = 1'b1;
      do_reset;
      wr(1, 1);
      chk(TRIM_A_O, 12'h05A);
      TRIM_LOCK_FUSE_I = 1'b0;
      $display("test trim done");
    end
  endtask
  task t_req;
    begin
      {REQ_ULP_I, WDT_EN_I, BOD_SAMPLED_I, RTC_EN_I} = 4'h8;
      for (i = 0; i < 4; i = i + 1) begin
        step(2);
        chk({ULP_STABLE_O, OSC_EN_O[1]}, 12'h003);
        {REQ_ULP_I, WDT_EN_I, BOD_SAMPLED_I, RTC_EN_I} = 4'h4 >> i;
      end
      step(1);
      chk(OSC_EN_O[1], 12'h000);
      REQ_XTAL_I = 1'b1;
      step(2);
      chk(OSC_EN_O[2], 12'h000);
      {WR_STDBY_I, WR_XTAL_EN_I} = 5'h05;
      wr(4, 1);
      runs(2'h2, 1'b0);
      chk({XTAL_STABLE_O, OSC_EN_O[2:1]}, 12'h007);
      SLEEP_MODE_I = 2'h3;
      step(1);
      chk(OSC_EN_O[1], 12'h000);
      {WR_STDBY_I, WR_XTAL_EN_I, REQ_XTAL_I} = 6'h00;
      wr(4, 1);
      $display("test requests done");
    end
  endtask
  task t_sleep;
    begin
      runs(2'h1, 1'b1);
      runs(2'h2, 1'b0);
      REQ_MAIN_I = 1'b1;
      runs(2'h2, 1'b1);
      {REQ_MAIN_I, NVM_BUSY_I} = 2'h1;
      runs(2'h3, 1'b1);
      NVM_BUSY_I = 1'b0;
      runs(2'h3, 1'b0);
      runs(2'h0, 1'b1);
      $display("test sleep done");
    end
  endtask
  task t_switch;
    begin
      {REQ_ULP_I, WR_SRC_I} = 3'h5;
      wr(2, 1);
      chk(SWITCHING_O, 12'h001);
      wait_sw;
      chk({SWITCHING_O, SRC_SEL_O}, 12'h001);
      {REQ_FAST_I, WR_SRC_I} = 3'h4;
      wr(2, 1);
      wait_sw;
      chk({SWITCHING_O, SRC_SEL_O}, 12'h000);
      {REQ_FAST_I, REQ_ULP_I, REQ_EXT_I, WR_SRC_I} = 5'h0B;
      wr(2, 1);
      step(40);
      chk({EXT_STABLE_O, SWITCHING_O, SRC_SEL_O}, 12'h004);
      {REQ_ULP_I, WR_SRC_I} = 3'h5;
      wr(2, 1);
      step(20);
      chk({SWITCHING_O, SRC_SEL_O}, 12'h004);
      do_reset;
      {ext_run, REQ_ULP_I, WR_SRC_I} = 4'hB;
      wr(2, 1);
      wait_sw;
      chk({EXT_STABLE_O, SWITCHING_O, SRC_SEL_O}, 12'h00B);
      $display("test switch done");
    end
  endtask
  // stops a hung run well past the expected length
  initial begin
    #800000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    {REQ_FAST_I, REQ_ULP_I, REQ_XTAL_I, REQ_EXT_I, REQ_MAIN_I} = 5'h00;
    {RTC_EN_I, RTC_ON_XTAL_I, WDT_EN_I, BOD_SAMPLED_I, NVM_BUSY_I} = 5'h00;
    {UNLOCK_KEY_I, WR_MAIN_A_I, WR_PIN_OUT_I, WR_PRESC_I, WR_PEN_I} = 5'h00;
    {WR_TRIM_LOCK_ENABLE_I, WR_TRIM_LOCK_ENABLE_D_I, WR_TRIM_A_I, WR_TRIM_B_I} = 4'h0;
    {WR_OSC_CTL_I, WR_XTAL_EN_I, ext_run, TRIM_LOCK_FUSE_I} = 4'h0;
    {SLEEP_MODE_I, WR_SRC_I, WR_TRIM_A_D_I} = 11'h000;
    {WR_DIV_I, WR_TRIM_B_D_I, WR_STDBY_I} = 12'h000;
    {FREQ_FUSE_I, TRIM_A_FUSE_I, TRIM_B_FUSE_I} = 13'h15A6;
    {CE_I, RESET_I} = 2'h3;
    failures = 0;
    samples_checked = 0;
    do_reset;
    t_reset;
    t_presc;
    t_trim;
    t_req;
    t_sleep;
    t_switch;
    summarize;
  end
endmodule // tb
